// *** hall_autotune_compensation.sv ***
// Function
// - per plate, tuning derives coarse, fine and compensation from base and target
// - first phase: compensation zero, step multipliers until reference reaches base
// - then raise compensation until reference reaches target
// - plate reference is one over twice the sum of channel reciprocals
// - top and bottom reciprocal differences; ratio is factor times top over bottom
// - track crossings and term extrema; factor is bottom max over top max
// - factor changes only on a host restore, or at a crossing when both peaks were seen before it
// - at startup the factor is exactly one
// - swing factor applies only to the ratio, never to raw counts
// - refreshed factor exists only after the magnet completes a segment
// - plate 1 uses channels two and three, plate 2 four and five
`timescale 1ns/1ps
`default_nettype none
module hall_autotune_compensation #(
  parameter int CNT_W = 16
) (
  input  wire logic              clk_i,          // 250 MHz clock
  input  wire logic              reset_n_i,      // sync reset, active low
  input  wire logic [CNT_W-1:0]  p1_noninv_i,    // plate1_noninverted_channel count
  input  wire logic [CNT_W-1:0]  p1_inv_i,       // plate1_inverted_channel count
  input  wire logic [CNT_W-1:0]  p2_noninv_i,    // plate2_noninverted_channel count
  input  wire logic [CNT_W-1:0]  p2_inv_i,       // plate2_inverted_channel count
  input  wire logic              sample_valid_i, // new set of counts
  input  wire logic              tune_start_i,   // start auto_tuning
  input  wire logic [CNT_W-1:0]  base_p1_i,      // plate 1 base value
  input  wire logic [CNT_W-1:0]  target_p1_i,    // plate 1 target value
  input  wire logic [CNT_W-1:0]  base_p2_i,      // plate 2 base value
  input  wire logic [CNT_W-1:0]  target_p2_i,    // plate 2 target value
  input  wire logic [7:0]        reg_addr_i,     // register offset
  input  wire logic              reg_wr_i,       // write strobe
  input  wire logic [7:0]        reg_wdata_i,    // write data
  input  wire logic              reg_rd_i,       // read strobe
  output logic      [7:0]        reg_rdata_o,    // read data, next cycle
  output logic      [7:0]        mult_p1_o,      // plate 1 {coarse,fine}
  output logic      [7:0]        comp_p1_o,      // plate 1 compensation
  output logic      [7:0]        mult_p2_o,      // plate 2 {coarse,fine}
  output logic      [7:0]        comp_p2_o,      // plate 2 compensation
  output logic      [15:0]       ratio_o,        // compensated ratio, q8.8
  output logic      [15:0]       kappa_o         // swing factor, q8.8
);
  initial begin
    if (CNT_W < 8 || CNT_W > 24) $error("CNT_W out of range");
  end

  function automatic logic [CNT_W-1:0] ref_f(input logic [CNT_W-1:0] a,
                                             input logic [CNT_W-1:0] b);
    logic [CNT_W+1:0] s;
    s = ({2'b00, a} + {2'b00, b}) << 1;
    ref_f = (s == '0) ? '0 : CNT_W'(({{CNT_W{1'b0}}, a} * {{CNT_W{1'b0}}, b}) / s);
  endfunction : ref_f

  function automatic logic signed [25:0] recip_f(input logic [CNT_W-1:0] x);
    recip_f = (x == '0) ? '0 : $signed({1'b0, 25'(hall_tune_pkg::RECIP_NUM / x)});
  endfunction : recip_f

  hall_tune_pkg::tune_state_t state;
  logic                       plate;
  logic [CNT_W-1:0]           ref1, ref2, cur_ref, cur_base, cur_target;
  logic [7:0]                 mult [2];
  logic [7:0]                 comp [2];
  logic [7:0]                 pointer;
  logic [15:0]                kappa;
  logic signed [25:0]         rt, rb, max_rt, max_rb, min_rt, min_rb;
  logic                       rt_rise, rb_rise, rt_peak, rb_peak, have_prev, prev_sign;
  logic                       crossing, data_wr;
  logic signed [42:0]         prod;

  assign ref1 = ref_f(p1_noninv_i, p1_inv_i);
  assign ref2 = ref_f(p2_noninv_i, p2_inv_i);
  assign cur_ref    = plate ? ref2 : ref1;
  assign cur_base   = plate ? base_p2_i : base_p1_i;
  assign cur_target = plate ? target_p2_i : target_p1_i;
  assign rt = recip_f(p2_noninv_i) - recip_f(p1_noninv_i);
  assign rb = recip_f(p2_inv_i) - recip_f(p1_inv_i);
  assign crossing = sample_valid_i && have_prev && (rt[25] != prev_sign);
  assign data_wr  = reg_wr_i && reg_addr_i == hall_tune_pkg::INDIRECT_DATA_OFS;
  // full-width product so a large factor cannot wrap before the divide
  assign prod = $signed({{27{1'b0}}, kappa}) * $signed({{17{rt[25]}}, rt});

  // tuning sequence, plate 1 then plate 2
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state <= hall_tune_pkg::TUNE_IDLE;
      plate <= 1'b0;
      mult  <= '{8'h00, 8'h00};
      comp  <= '{8'h00, 8'h00};
    end else begin
      case (state)
        hall_tune_pkg::TUNE_IDLE: begin
          if (tune_start_i) begin
            state <= hall_tune_pkg::TUNE_MULT;
            plate <= 1'b0;
            mult  <= '{8'h00, 8'h00};
            comp  <= '{8'h00, 8'h00};
          end
        end
        hall_tune_pkg::TUNE_MULT: begin
          comp[plate] <= 8'h00;
          if (sample_valid_i) begin
            if (cur_ref < cur_base && mult[plate] != hall_tune_pkg::MULT_MAX)
              mult[plate] <= mult[plate] + 8'h01;
            else
              state <= hall_tune_pkg::TUNE_COMP;
          end
        end
        hall_tune_pkg::TUNE_COMP: begin
          if (sample_valid_i) begin
            if (cur_ref < cur_target && comp[plate] != hall_tune_pkg::COMP_MAX) begin
              comp[plate] <= comp[plate] + 8'h01;
            end else if (!plate) begin
              plate <= 1'b1;
              state <= hall_tune_pkg::TUNE_MULT;
            end else begin
              state <= hall_tune_pkg::TUNE_IDLE;
            end
          end
        end
        default: state <= hall_tune_pkg::TUNE_IDLE;
      endcase
    end
  end

  // extrema tracking between crossings
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || crossing) begin
      max_rt  <= '0;
      max_rb  <= '0;
      min_rt  <= '0;
      min_rb  <= '0;
      rt_rise <= 1'b0;
      rb_rise <= 1'b0;
      rt_peak <= 1'b0;
      rb_peak <= 1'b0;
    end else if (sample_valid_i) begin
      if (rt > max_rt) begin
        max_rt  <= rt;
        rt_rise <= 1'b1;
      end else if (rt_rise && rt < max_rt) begin
        rt_peak <= 1'b1;
      end
      if (rb > max_rb) begin
        max_rb  <= rb;
        rb_rise <= 1'b1;
      end else if (rb_rise && rb < max_rb) begin
        rb_peak <= 1'b1;
      end
      if (rt < min_rt) min_rt <= rt;
      if (rb < min_rb) min_rb <= rb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      have_prev <= 1'b0;
      prev_sign <= 1'b0;
    end else if (sample_valid_i) begin
      have_prev <= 1'b1;
      prev_sign <= rt[25];
    end
  end

  // swing factor: learned at crossings, restored by the host
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      kappa <= hall_tune_pkg::KAPPA_ONE;
    end else if (data_wr && pointer == hall_tune_pkg::FIRST_COMP_CODE) begin
      kappa[7:0] <= reg_wdata_i;
    end else if (data_wr && pointer == hall_tune_pkg::SECOND_COMP_CODE) begin
      kappa[15:8] <= reg_wdata_i;
    end else if (crossing && rt_peak && rb_peak && max_rt > 0) begin
      kappa <= 16'(({8'h00, max_rb} << hall_tune_pkg::KAPPA_FRAC)
                   / {8'h00, max_rt});
    end
  end

  // compensated ratio; raw counts pass untouched
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ratio_o <= 16'h0000;
    end else if (sample_valid_i && rb != 0) begin
      ratio_o <= 16'(prod / rb);
    end
  end

  // register port
  always_ff @(posedge clk_i) begin
    if (!reset_n_i)
      pointer <= hall_tune_pkg::POINTER_RESET;
    else if (reg_wr_i && reg_addr_i == hall_tune_pkg::INDIRECT_POINTER_OFS)
      pointer <= reg_wdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        hall_tune_pkg::SYSTEM_FLAGS_OFS:
          reg_rdata_o <= 8'(state != hall_tune_pkg::TUNE_IDLE)
                         << hall_tune_pkg::TUNING_BUSY_BIT;
        hall_tune_pkg::INDIRECT_POINTER_OFS: reg_rdata_o <= pointer;
        hall_tune_pkg::INDIRECT_DATA_OFS:
          reg_rdata_o <= (pointer == hall_tune_pkg::FIRST_COMP_CODE)  ? kappa[7:0] :
                         (pointer == hall_tune_pkg::SECOND_COMP_CODE) ? kappa[15:8] :
                         8'h00;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  assign mult_p1_o = mult[0];
  assign mult_p2_o = mult[1];
  assign comp_p1_o = comp[0];
  assign comp_p2_o = comp[1];
  assign kappa_o   = kappa;

  AST_KAPPA_ONE_AT_START: assert property (@(posedge clk_i)
    $rose(reset_n_i) |-> kappa == hall_tune_pkg::KAPPA_ONE)
    else $error("factor not one after reset");
  AST_COMP_ZERO_IN_MULT: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == hall_tune_pkg::TUNE_MULT ##1 state == hall_tune_pkg::TUNE_MULT
    |-> comp[plate] == 8'h00)
    else $error("compensation nonzero while stepping multipliers");
  AST_MULT_STEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == hall_tune_pkg::TUNE_MULT && sample_valid_i && cur_ref < cur_base
    && mult[plate] != hall_tune_pkg::MULT_MAX |=> mult[$past(plate)] == $past(mult[plate]) + 8'h01)
    else $error("multiplier did not step");
  AST_COMP_STOP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == hall_tune_pkg::TUNE_COMP && sample_valid_i && cur_ref >= cur_target
    |=> state != hall_tune_pkg::TUNE_COMP && $stable(comp_p1_o) && $stable(comp_p2_o))
    else $error("compensation moved past target");
  AST_POINTER_KEEP: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reg_wr_i && reg_addr_i == hall_tune_pkg::INDIRECT_POINTER_OFS
    |=> pointer == $past(reg_wdata_i))
    else $error("pointer not kept");
  AST_RESTORE_FIRST: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    data_wr && pointer == hall_tune_pkg::FIRST_COMP_CODE
    |=> kappa[7:0] == $past(reg_wdata_i))
    else $error("first word not restored");
  AST_RESTORE_SECOND: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    data_wr && pointer == hall_tune_pkg::SECOND_COMP_CODE
    |=> kappa[15:8] == $past(reg_wdata_i))
    else $error("second word not restored");
  AST_KAPPA_HOLD: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !data_wr && !(crossing && rt_peak && rb_peak) |=> $stable(kappa))
    else $error("factor changed without full segment");
  AST_BUSY_READ: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    state == hall_tune_pkg::TUNE_IDLE && tune_start_i ##1
    reg_rd_i && reg_addr_i == hall_tune_pkg::SYSTEM_FLAGS_OFS
    |=> reg_rdata_o[hall_tune_pkg::TUNING_BUSY_BIT])
    else $error("busy flag not shown");
endmodule : hall_autotune_compensation
`default_nettype wire

// *** hall_tune_pkg.sv ***
package hall_tune_pkg;
  localparam logic [7:0]  SYSTEM_FLAGS_OFS     = 8'h10;
  localparam logic [7:0]  INDIRECT_POINTER_OFS = 8'hf0;
  localparam logic [7:0]  INDIRECT_DATA_OFS    = 8'hf1;
  localparam logic [7:0]  FIRST_COMP_CODE      = 8'hd4;
  localparam logic [7:0]  SECOND_COMP_CODE     = 8'hd5;
  localparam int          TUNING_BUSY_BIT      = 0;
  localparam logic [7:0]  POINTER_RESET        = 8'h00;
  localparam logic [15:0] KAPPA_ONE            = 16'h0100;
  localparam int          KAPPA_FRAC           = 8;
  localparam logic [31:0] RECIP_NUM            = 32'h0100_0000;
  localparam logic [7:0]  MULT_MAX             = 8'hff;
  localparam logic [7:0]  COMP_MAX             = 8'hff;
  typedef enum logic [1:0] {
    TUNE_IDLE = 2'b00,
    TUNE_MULT = 2'b01,
    TUNE_COMP = 2'b10
  } tune_state_t;
endpackage : hall_tune_pkg

// *** hall_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module hall_host_model (
  input  wire logic       clk_i,   // bench clock
  input  wire logic [7:0] rdata_i, // read data from device
  output logic      [7:0] addr_o,  // register offset
  output logic            wr_o,    // write strobe
  output logic      [7:0] wdata_o, // write data
  output logic            rd_o     // read strobe
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one register access; released address and data lines show the inverse of the last value, both strobes drop low
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= wr;
    rd_o <= !wr;
    @(negedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
    q = rdata_i;
  endtask : xfer
  task automatic fetch_word(input logic [7:0] code, output logic [7:0] q);
    logic [7:0] u;
    xfer(1'b1, 8'hf0, code, u);
    xfer(1'b0, 8'hf1, 8'h00, q);
  endtask : fetch_word
  task automatic restore_word(input logic [7:0] code, input logic [7:0] d);
    logic [7:0] u;
    xfer(1'b1, 8'hf0, code, u);
    xfer(1'b1, 8'hf1, d, u);
  endtask : restore_word
endmodule : hall_host_model
`default_nettype wire

// *** hall_autotune_compensation_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module hall_autotune_compensation_test;
  logic        clk_i, reset_n_i, sv, ts, rw, rr;
  logic [15:0] c1, c2, c4, ratio, kappa;
  logic [7:0]  ra, wd, rq, q, m1, k1, m2, k2, b1, b2;
  int miscompares = 0, cmp_count = 0, cyc = 0, seed = 48271;
  int ph = 0, em1 = 0, ec1 = 0, em2 = 0, ec2 = 0;
  int tab[9] = '{200, 200, 200, 600, 600, 600, 2000, 2000, 2000};
  int rot_n[6] = '{1100, 900, 800, 900, 1100, 900};
  int rot_i[6] = '{1100, 900, 700, 900, 1100, 900};
  int ek = 256, mt = 0, mb = 0, tp = 0, bp = 0, et = 0, eb = 0, ps = 1;
  hall_autotune_compensation hall_autotune_compensation_i (.clk_i(clk_i),
    .reset_n_i(reset_n_i), .p1_noninv_i(c1), .p1_inv_i(c1), .p2_noninv_i(c2),
    .p2_inv_i(c4), .sample_valid_i(sv), .tune_start_i(ts), .base_p1_i(16'h0096),
    .target_p1_i(16'h01f4), .base_p2_i(16'h0096), .target_p2_i(16'h01f4),
    .reg_addr_i(ra), .reg_wr_i(rw), .reg_wdata_i(wd), .reg_rd_i(rr),
    .reg_rdata_o(rq), .mult_p1_o(m1), .comp_p1_o(k1), .mult_p2_o(m2),
    .comp_p2_o(k2), .ratio_o(ratio), .kappa_o(kappa));
  hall_host_model hall_host_model_i (.clk_i(clk_i), .rdata_i(rq), .addr_o(ra),
    .wr_o(rw), .wdata_o(wd), .rd_o(rr));
  function automatic int xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    hall_host_model_i.xfer(1'b0, a, 8'h00, d);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] u;
    hall_host_model_i.xfer(1'b1, a, d, u);
  endtask : wr
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  initial begin
    {reset_n_i, sv, ts} = 3'b000;
    c1 = 16'h0000;
    c2 = 16'd2001;
    c4 = 16'd2001;
    repeat (12) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk("kappa", kappa, 16'h0100);
    hall_host_model_i.fetch_word(8'hd5, q);
    chk("word2", q, 8'h01);
    rd(8'h10, q);
    chk("flags", q, 8'h00);
    @(negedge clk_i) ts <= 1'b1;
    rd(8'h10, q);
    chk("busy start", q, 8'h01);
    ts <= 1'b0;
    foreach (tab[i]) begin
      @(negedge clk_i);
      c1 <= 16'(tab[i]);
      sv <= 1'b1;
      ts <= (i == 4);
      @(negedge clk_i);
      sv <= 1'b0;
      ts <= 1'b0;
      // per-plate reference is a/4 for equal channel counts
      case (ph)
        0: if (tab[i] / 4 < 150) em1++; else ph = 1;
        1: if (tab[i] / 4 < 500) ec1++; else ph = 2;
        2: if (2001 / 4 < 150) em2++; else ph = 3;
        default: if (2001 / 4 < 500) ec2++; else ph = 4;
      endcase
      chk("ratio", ratio, 16'h0100);
      chk("mult1", m1, 8'(em1));
      chk("first_compensation_word", k1, 8'(ec1));
      chk("mult2", m2, 8'(em2));
      chk("second_compensation_word", k2, 8'(ec2));
      rd(8'h10, q);
      chk("busy", q, {7'h00, ph != 4});
      chk("kappa", kappa, 16'h0100);
    end
    // one segment with both peaks, then a crossing straight back without one;
    // the last tuning sample left the top term negative (ps = 1)
    foreach (rot_n[i]) begin
      et = (1 << 24) / rot_n[i] - (1 << 24) / 1000;
      eb = (1 << 24) / rot_i[i] - (1 << 24) / 1000;
      @(negedge clk_i);
      c1 <= 16'd1000;
      c2 <= 16'(rot_n[i]);
      c4 <= 16'(rot_i[i]);
      sv <= 1'b1;
      @(negedge clk_i);
      sv <= 1'b0;
      chk("ratio", ratio, 16'((ek * et) / eb));
      if ((et < 0) != ps) begin
        if (tp && bp && mt > 0) ek = (mb * 256) / mt;
        mt = 0;
        mb = 0;
        tp = 0;
        bp = 0;
      end else begin
        if (et > mt) mt = et;
        else if (mt > 0 && et < mt) tp = 1;
        if (eb > mb) mb = eb;
        else if (mb > 0 && eb < mb) bp = 1;
      end
      ps = (et < 0);
      chk("kappa", kappa, 16'(ek));
    end
    repeat (3) begin
      b1 = 8'(xs());
      b2 = 8'(xs());
      hall_host_model_i.restore_word(8'hd4, b1);
      hall_host_model_i.restore_word(8'hd5, b2);
      chk("kappa", kappa, {b2, b1});
      hall_host_model_i.fetch_word(8'hd4, q);
      chk("word1", q, b1);
      rd(8'hf1, q);
      chk("word1 again", q, b1);
    end
    wr(8'h10, 8'hff);
    rd(8'h10, q);
    chk("flags ro", q, 8'h00);
    rd(8'h55, q);
    chk("unmapped", q, 8'h00);
    wr(8'hf0, 8'h13);
    rd(8'hf0, q);
    chk("pointer", q, 8'h13);
    rd(8'hf1, q);
    chk("bad ptr", q, 8'h00);
    wr(8'hf1, 8'h5a);
    chk("kappa", kappa, {b2, b1});
    reset_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    reset_n_i = 1'b1;
    chk("kappa", kappa, 16'h0100);
    rd(8'hf0, q);
    chk("pointer", q, 8'h00);
    end_sim();
  end
endmodule : hall_autotune_compensation_test
`default_nettype wire
